//--- hw/rre_cfg.svh
`ifndef RRE_CFG_SVH
`define RRE_CFG_SVH
// data path and program counter widths
`define RRE_DW 8
`define RRE_PCW 13
// return stack depth and pointer width
`define RRE_STK_DEPTH 8
`define RRE_SPW 3
// interrupt vector used when a pending request is taken
`define RRE_IRQ_VEC 13'h0004
// reset values
`define RRE_PC_RST 13'h0000
`define RRE_WREG_RST 8'h00
// rotate edge bit positions
`define RRE_MSB 7
`define RRE_LSB 0
`endif

//--- hw/rre_pkg.sv
`include "rre_cfg.svh"
package rre_pkg;
  // instruction selector presented by the fetch/decode front end
  typedef enum logic [2:0] {
    RRE_OP_NONE,
    RRE_OP_OR_INTO_MEM,
    RRE_OP_SUBROUTINE_EXIT,
    RRE_OP_EXIT_LOAD_IMM,
    RRE_OP_IRQ_EXIT,
    RRE_OP_ROTATE_LEFT_MEM
  } rre_op_type;

  // one instruction issue
  typedef struct packed {
    logic valid;
    rre_op_type op;
    logic [`RRE_DW-1:0] imm;
    logic [`RRE_DW-1:0] mem_rdata;
  } rre_issue_type;

  // data memory write-back
  typedef struct packed {
    logic we;
    logic [`RRE_DW-1:0] wdata;
  } rre_memwr_type;
endpackage

//--- hw/rre_exec.sv
`include "rre_cfg.svh"
// Summary of operation
// - or-into-mem writes working_register OR byte; zero flag
// - subroutine_exit pops stack into program counter
// - exit_load_imm pops stack, loads immediate
// - irq_exit with no request pending pops stack, sets global_irq_enable
// - pending interrupt serviced before main program resumes
// - rotate_left_mem rotates byte, bit7 to bit0
module rre_exec
(
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire rre_pkg::rre_issue_type i_issue,
  input wire logic i_call_push,
  input wire logic [`RRE_PCW-1:0] i_call_pc,
  input wire logic i_irq_pending,
  input wire logic i_irq_enable_clr,
  output rre_pkg::rre_memwr_type o_memwr,
  output logic [`RRE_PCW-1:0] o_pc,
  output logic o_pc_load,
  output logic [`RRE_DW-1:0] o_working_register,
  output logic o_zero_flag,
  output logic o_global_irq_enable,
  output logic o_irq_taken
);
  import rre_pkg::*;

  // return stack storage and pointer; only the pointer is reset
  logic [`RRE_PCW-1:0] stack_q [`RRE_STK_DEPTH];
  logic [`RRE_SPW-1:0] sp_q; // next free slot, wraps past the last one
  logic [`RRE_PCW-1:0] pc_q; // redirect target handed to fetch
  logic pc_load_q; // one-cycle redirect strobe
  logic [`RRE_DW-1:0] wreg_q; // working register
  logic zero_q; // result-nil flag
  logic gie_q; // global_irq_enable
  logic taken_q; // one-cycle strobe: pending irq taken at exit
  rre_memwr_type memwr_q; // registered write-back to data memory
  // decoded issue strobes
  logic is_or; // or_into_mem
  logic is_sub_exit; // subroutine_exit
  logic is_irq_exit; // irq_exit
  logic is_imm_exit; // exit_load_imm
  logic is_rot; // rotate_left_mem
  logic is_pop; // any of the three exits
  logic take_irq; // irq_exit meets a pending request
  logic [`RRE_SPW-1:0] sp_top; // slot of the last pushed address

  // one-bit rotate toward the msb with wrap
  function automatic logic [`RRE_DW-1:0] rot_left(input logic [`RRE_DW-1:0] v);
    rot_left = {v[`RRE_MSB-1:`RRE_LSB], v[`RRE_MSB]};
  endfunction

  // true when a valid issue carries the given operation
  function automatic logic op_is(input rre_issue_type iss, input rre_op_type op);
    op_is = iss.valid && (iss.op == op);
  endfunction

  // decode the presented instruction; unused codes decode to nothing
  always_comb
  begin
    is_or = op_is(i_issue, RRE_OP_OR_INTO_MEM);
    is_sub_exit = op_is(i_issue, RRE_OP_SUBROUTINE_EXIT);
    is_imm_exit = op_is(i_issue, RRE_OP_EXIT_LOAD_IMM);
    is_irq_exit = op_is(i_issue, RRE_OP_IRQ_EXIT);
    is_rot = op_is(i_issue, RRE_OP_ROTATE_LEFT_MEM);
    is_pop = is_sub_exit || is_imm_exit || is_irq_exit;
    // an empty stack wraps to the last slot; its content is then undefined
    sp_top = sp_q - 1'b1;
  end

  // a pending request right at irq_exit is taken at once, so the
  // handler runs before any main-program instruction
  // pending irq first
  assign take_irq = is_irq_exit && i_irq_pending;

  // return stack push/pop; taking the irq leaves the return address stacked
  // so that the handler's own exit goes back to the main program
  // a push that meets a pop is dropped: the core never calls while returning
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      sp_q <= '0;
    end
    else if (i_call_push && !is_pop)
    begin
      stack_q[sp_q] <= i_call_pc;
      sp_q <= sp_q + 1'b1;
    end
    else if (is_pop && !take_irq)
    begin
      sp_q <= sp_top;
    end
  end

  // program counter redirect
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      pc_q <= `RRE_PC_RST;
      pc_load_q <= 1'b0;
    end
    else
    begin
      pc_load_q <= is_pop;
      if (take_irq)
        pc_q <= `RRE_IRQ_VEC;
      else if (is_pop)
        pc_q <= stack_q[sp_top];
    end
  end

  // working register and zero flag; other flags are not touched here
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      wreg_q <= `RRE_WREG_RST;
      zero_q <= 1'b0;
    end
    else if (is_imm_exit)
    begin
      wreg_q <= i_issue.imm;
    end
    else if (is_or)
    begin
      // zero flag only
      // the result goes to memory, so the working register keeps its value
      zero_q <= ((wreg_q | i_issue.mem_rdata) == '0);
    end
  end

  // data memory write-back
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
      memwr_q <= '0;
    else
    begin
      // strobe for one cycle only; data holds so the bus does not toggle
      memwr_q.we <= is_or || is_rot;
      if (is_or)
        memwr_q.wdata <= wreg_q | i_issue.mem_rdata;
      else if (is_rot)
        memwr_q.wdata <= rot_left(i_issue.mem_rdata);
    end
  end

  // global enable: set by irq_exit, cleared when the core enters a handler
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      gie_q <= 1'b0;
      taken_q <= 1'b0;
    end
    else
    begin
      taken_q <= take_irq;
      // set enable; entry clears
      // taking the pending request is a handler entry, so enable stays low
      if (take_irq)
        gie_q <= 1'b0;
      // the set wins over a clear from the core in the same cycle
      else if (is_irq_exit)
        gie_q <= 1'b1;
      else if (i_irq_enable_clr)
        gie_q <= 1'b0;
    end
  end

  assign o_memwr = memwr_q;
  assign o_pc = pc_q;
  assign o_pc_load = pc_load_q;
  assign o_working_register = wreg_q;
  assign o_zero_flag = zero_q;
  assign o_global_irq_enable = gie_q;
  assign o_irq_taken = taken_q;

  // a memory rotate being issued; its write-back follows one cycle later
  sequence s_rot_issue;
    is_rot;
  endsequence
  // rotated byte written, built bit by bit rather than through rot_left
  property p_rot;
    @(posedge i_mclk) disable iff (i_srst)
      s_rot_issue |=> o_memwr.we
        && o_memwr.wdata == {$past(i_issue.mem_rdata[`RRE_MSB-1:`RRE_LSB]), $past(i_issue.mem_rdata[`RRE_MSB])};
  endproperty
  a_rot: assert property (p_rot) else $error("rotate result wrong");
  // rotate touches neither the flag nor the working register
  property p_rot_flags;
    @(posedge i_mclk) disable iff (i_srst)
      s_rot_issue |=> $stable(o_zero_flag) && $stable(o_working_register);
  endproperty
  a_rot_flags: assert property (p_rot_flags) else $error("rotate touched a flag");
  property p_or;
    @(posedge i_mclk) disable iff (i_srst)
      is_or |=> o_memwr.we && o_memwr.wdata == ($past(wreg_q) | $past(i_issue.mem_rdata));
  endproperty
  a_or: assert property (p_or) else $error("or result wrong");
  // zero flag follows the written result; the working register keeps its value
  property p_or_zero;
    @(posedge i_mclk) disable iff (i_srst)
      is_or |=> o_zero_flag == (($past(wreg_q) | $past(i_issue.mem_rdata)) == '0)
        && $stable(o_working_register);
  endproperty
  a_or_zero: assert property (p_or_zero) else $error("or zero flag wrong");
  property p_imm_exit;
    @(posedge i_mclk) disable iff (i_srst)
      is_imm_exit |=> o_working_register == $past(i_issue.imm) && o_pc_load;
  endproperty
  a_imm_exit: assert property (p_imm_exit) else $error("immediate not loaded");
  property p_sub_exit;
    @(posedge i_mclk) disable iff (i_srst)
      is_sub_exit |=> o_pc_load && $stable(o_zero_flag);
  endproperty
  a_sub_exit: assert property (p_sub_exit) else $error("return bad");
  property p_irq_exit;
    @(posedge i_mclk) disable iff (i_srst)
      (is_irq_exit && !i_irq_pending) |=> o_global_irq_enable;
  endproperty
  a_irq_exit: assert property (p_irq_exit) else $error("enable not set");
  // the handler is entered with the enable low, at the vector
  property p_pend;
    @(posedge i_mclk) disable iff (i_srst)
      take_irq |=> o_pc == `RRE_IRQ_VEC && o_irq_taken && !o_global_irq_enable;
  endproperty
  a_pend: assert property (p_pend) else $error("pending irq not taken");
endmodule

//--- test/testbench.sv
`include "rre_cfg.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import rre_pkg::*;
  logic i_mclk = 0, i_srst = 1, i_call_push = 0, i_irq_pending = 0, i_irq_enable_clr = 0;
  logic [`RRE_PCW-1:0] i_call_pc = '0, o_pc;
  rre_issue_type i_issue = '0;
  rre_memwr_type o_memwr;
  logic o_pc_load, o_zero_flag, o_global_irq_enable, o_irq_taken;
  logic [7:0] o_working_register;
  // bench copy of the return stack and core state
  logic [`RRE_PCW-1:0] stk [8];
  logic [7:0] wreg = 8'h00;
  logic zf = 0, en = 0;
  logic [31:0] lfsr = 32'h4c55;
  int sp = 0, errors = 0, compares = 0, cyc = 0;
  always #4 i_mclk = ~i_mclk;
  rre_exec i_dut (.i_mclk(i_mclk), .i_srst(i_srst), .i_issue(i_issue), .i_call_push(i_call_push),
    .i_call_pc(i_call_pc), .i_irq_pending(i_irq_pending), .i_irq_enable_clr(i_irq_enable_clr),
    .o_memwr(o_memwr), .o_pc(o_pc), .o_pc_load(o_pc_load), .o_working_register(o_working_register),
    .o_zero_flag(o_zero_flag), .o_global_irq_enable(o_global_irq_enable), .o_irq_taken(o_irq_taken));
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // expected write-back byte for the two memory ops
  function automatic logic [7:0] wexp(input rre_op_type op, input logic [7:0] a, m);
    return (op == RRE_OP_OR_INTO_MEM) ? (a | m) : {m[6:0], m[7]};
  endfunction
  // one compare task per kind of result; !== keeps unknowns from passing
  task automatic cmp_bit(input string what, input logic got, input logic exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask
  task automatic cmp_byte(input string what, input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic cmp_pc(input string what, input logic [`RRE_PCW-1:0] got, input logic [`RRE_PCW-1:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // push one return address, kept in step with the bench stack
  task automatic push(input logic [`RRE_PCW-1:0] pc);
    @(posedge i_mclk) #1;
    i_call_push = 1;
    i_call_pc = pc;
    stk[sp] = pc;
    sp++;
    @(posedge i_mclk) #1;
    i_call_push = 0;
  endtask
  // issue one op; pending level and enable clear go with it
  task automatic run(input rre_op_type op, input logic [7:0] imm, m, input logic pend, clr);
    logic ld, tk, we;
    logic [`RRE_PCW-1:0] epc;
    @(posedge i_mclk) #1;
    i_issue = {1'b1, op, imm, m};
    i_irq_pending = pend;
    i_irq_enable_clr = clr;
    ld = op inside {RRE_OP_SUBROUTINE_EXIT, RRE_OP_EXIT_LOAD_IMM, RRE_OP_IRQ_EXIT};
    tk = op == RRE_OP_IRQ_EXIT && pend;
    we = op inside {RRE_OP_OR_INTO_MEM, RRE_OP_ROTATE_LEFT_MEM};
    epc = `RRE_IRQ_VEC;
    if (ld && !tk)
    begin
      sp--;
      epc = stk[sp];
    end
    // a clear from the core loses to the set; a taken request keeps it low
    if (clr) en = 0;
    if (op == RRE_OP_IRQ_EXIT) en = !tk;
    if (op == RRE_OP_OR_INTO_MEM) zf = (wreg | m) == 8'h00;
    @(posedge i_mclk) #1;
    i_issue.valid = 0;
    i_irq_enable_clr = 0;
    cmp_bit("we", o_memwr.we, we);
    if (we) cmp_byte("wdata", o_memwr.wdata, wexp(op, wreg, m));
    if (op == RRE_OP_EXIT_LOAD_IMM) wreg = imm;
    cmp_bit("pc_load", o_pc_load, ld);
    if (ld) cmp_pc("pc", o_pc, epc);
    cmp_bit("taken", o_irq_taken, tk);
    cmp_byte("wreg", o_working_register, wreg);
    cmp_bit("zero", o_zero_flag, zf);
    cmp_bit("enable", o_global_irq_enable, en);
  endtask
  initial
  begin
    repeat (2) @(posedge i_mclk);
    #1 i_srst = 0;
    // every output but the write data at its reset value before the first issue
    cmp_pc("pc", o_pc, `RRE_PC_RST);
    cmp_bit("pc_load", o_pc_load, 1'b0);
    cmp_bit("we", o_memwr.we, 1'b0);
    cmp_byte("wreg", o_working_register, `RRE_WREG_RST);
    cmp_bit("zero", o_zero_flag, 1'b0);
    cmp_bit("enable", o_global_irq_enable, 1'b0);
    cmp_bit("taken", o_irq_taken, 1'b0);
    // full stack, then drained in reverse order
    for (int k = 0; k < 8; k++) push(13'h1000 + 13'(k * 77));
    for (int k = 0; k < 8; k++) run(RRE_OP_SUBROUTINE_EXIT, 8'h00, 8'h00, 0, 0);
    // zero result, rotate edge bit, pending at exit keeps stack
    push(13'h0abc);
    run(RRE_OP_EXIT_LOAD_IMM, 8'h00, 8'h00, 0, 0);
    run(RRE_OP_OR_INTO_MEM, 8'h00, 8'h00, 0, 0);
    run(RRE_OP_ROTATE_LEFT_MEM, 8'h00, 8'h80, 0, 0);
    push(13'h0123);
    run(RRE_OP_IRQ_EXIT, 8'h00, 8'h00, 1, 0);
    run(RRE_OP_IRQ_EXIT, 8'h00, 8'h00, 0, 0);
    // enable set and core clear in one cycle: the set wins
    push(13'h0456);
    run(RRE_OP_IRQ_EXIT, 8'h00, 8'h00, 0, 1);
    for (int i = 0; i < 300; i++)
    begin
      lfsr = nxt(lfsr);
      if (sp == 0 || (sp < 8 && lfsr[9])) push(lfsr[28:16]);
      run(rre_op_type'(3'(lfsr[2:0] % 5 + 1)), lfsr[15:8], lfsr[23:16], lfsr[5], lfsr[6]);
    end
    complete_run;
  end
  // hang guard
  always @(posedge i_mclk)
  begin
    cyc++;
    if (cyc > 3000)
    begin
      errors++;
      complete_run;
    end
  end
endmodule
